/* uwo_defines.svh */
// Constants for the store ordering block
`ifndef UWO_DEFINES_SVH
`define UWO_DEFINES_SVH
`define UWO_ADDR_W      32
`define UWO_DATA_W      32
`define UWO_CNT_W       4
`define UWO_CNT_MAX     4'hf
`define UWO_KIND_W      2
`define UWO_KIND_WC     2'h0
`define UWO_KIND_UC_ST  2'h1
`define UWO_KIND_UC_LD  2'h2
`define UWO_KIND_SWAP   2'h3
`endif

/* uwo_pkg.sv */
// Types for the store ordering block
`include "uwo_defines.svh"
package uwo_pkg;
    typedef struct packed {
        logic [`UWO_KIND_W-1:0] kind;
        logic [`UWO_ADDR_W-1:0] addr;
        logic [`UWO_DATA_W-1:0] data;
    } uwo_req_t;
    typedef enum logic [1:0] {
        UWO_IDLE,
        UWO_ISSUE,
        UWO_WAIT
    } uwo_state_t;
endpackage

/* uwo_order.sv */
// Bus ordering of write-combine and uncached transactions
`timescale 1ns/1ps
`default_nettype none
`include "uwo_defines.svh"
module uwo_order
(
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             req_valid_i,
    input  wire uwo_pkg::uwo_req_t req_i,
    output var  logic             req_ready_o,
    output var  logic             bus_valid_o,
    output var  uwo_pkg::uwo_req_t bus_req_o,
    input  wire logic             bus_accept_i,
    input  wire logic             bus_done_i,
    input  wire logic             bus_retry_i,
    output var  logic             wc_busy_o
);
    import uwo_pkg::*;

    // How ordering is kept:
    // - the core hands over one request at a time, so requests leave in
    //   the order the core issued them;
    // - write-combine writes are posted: the core is freed once the bus
    //   accepts one, and a counter tracks those not yet finished;
    // - an uncached store, uncached load or swap is launched only when
    //   that counter is zero and no retry is in flight, and the core is
    //   held until the bus reports it done without retry;
    // - a retry of a write-combine write keeps it counted, so a later
    //   uncached access cannot overtake the reissued chunk.
    // Timing: a write-combine request reaches the bus two edges after it
    //   is taken; ready returns one edge after the bus accepts it.
    // Uncached work launches two edges after the take at the earliest.
    // Limitation: at most 15 writes may be open; a sixteenth waits,
    // trading a little throughput for a narrow counter.

    // Control group: where the held request stands
    uwo_state_t             state_reg;
    uwo_state_t             state_next;
    uwo_req_t               cur_reg;
    uwo_req_t               cur_next;
    logic                   valid_reg;
    logic                   valid_next;
    logic                   ready_reg;
    logic                   ready_next;

    // Counter group: open write-combine writes on the bus
    logic [`UWO_CNT_W-1:0]  open_reg;
    logic [`UWO_CNT_W-1:0]  open_next;
    logic                   busy_reg;
    logic                   busy_next;

    // Conditions used by one group or both
    // Next values are computed below; the registers only copy them
    logic                   is_wc;
    logic                   take;
    logic                   accept_now;
    logic                   done_clean;
    logic                   drained;
    logic                   wc_room;
    logic                   may_launch;
    logic                   inc;
    logic                   dec;

    // The held request is a write-combine write
    assign is_wc = (cur_reg.kind == `UWO_KIND_WC);

    // A core request is taken only while ready is shown
    assign take = req_valid_i && ready_reg;

    // The bus takes the request on the edge it sees valid and accept
    assign accept_now = valid_reg && bus_accept_i;

    // A done pulse with retry means the transfer must run again
    assign done_clean = bus_done_i && !bus_retry_i;

    // No write is open and none is being retried right now;
    // a retry pulse alone already blocks uncached work
    assign drained = (open_reg == '0) && !bus_retry_i;

    // The counter must not wrap, so a full count stalls more writes
    assign wc_room = (open_reg != `UWO_CNT_MAX);

    // Write-combine writes may overlap; all other work waits until
    // every earlier write has drained
    always_comb
    begin
        if (is_wc)
            may_launch = wc_room;
        else
            may_launch = drained;
    end

    // Control next state: one request held at a time keeps program order
    always_comb
    begin
        state_next = state_reg;
        cur_next   = cur_reg;
        valid_next = valid_reg;
        ready_next = ready_reg;
        inc        = 1'b0;
        case (state_reg)
            UWO_IDLE:
            begin
                // Ready comes up one edge after reset or after a release
                ready_next = 1'b1;
                if (take)
                begin
                    // Capture the whole request so the bus copy holds
                    cur_next   = req_i;
                    ready_next = 1'b0;
                    state_next = UWO_ISSUE;
                end
            end
            UWO_ISSUE:
            begin
                // Valid, once raised, stands until the bus accepts
                if (may_launch)
                    valid_next = 1'b1;
                if (accept_now)
                begin
                    valid_next = 1'b0;
                    if (is_wc)
                    begin
                        // A posted write frees the core at once
                        inc        = 1'b1;
                        state_next = UWO_IDLE;
                        ready_next = 1'b1;
                    end
                    else
                    begin
                        // Uncached work waits for its own done pulse
                        state_next = UWO_WAIT;
                    end
                end
            end
            UWO_WAIT:
            begin
                // Nothing later starts until the uncached access completes
                if (done_clean)
                begin
                    // Finished; later writes may now start
                    state_next = UWO_IDLE;
                    ready_next = 1'b1;
                end
                else if (bus_retry_i)
                begin
                    // A retried uncached access is sent again
                    state_next = UWO_ISSUE;
                end
            end
            default:
            begin
                // An unused code falls back to idle
                state_next = UWO_IDLE;
            end
        endcase
    end

    // Counter next state: retried writes stay counted until a done pulse without retry
    always_comb
    begin
        // Done pulses during an uncached wait belong to that access
        dec       = done_clean && (state_reg != UWO_WAIT)
                    && (open_reg != '0);
        // Increment and decrement in one cycle cancel out
        open_next = open_reg + {{(`UWO_CNT_W-1){1'b0}}, inc}
                    - {{(`UWO_CNT_W-1){1'b0}}, dec};
        busy_next = (open_next != '0);
    end

    // Control registers
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            // Reset leaves the core blocked for one edge
            state_reg <= UWO_IDLE;
            cur_reg   <= '0;
            valid_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cur_reg   <= cur_next;
            valid_reg <= valid_next;
            ready_reg <= ready_next;
        end
    end

    // Counter registers
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            open_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            open_reg <= open_next;
            busy_reg <= busy_next;
        end
    end

    // Every output is a register, so the far side sees no glitches
    assign req_ready_o = ready_reg;
    assign bus_valid_o = valid_reg;
    assign bus_req_o   = cur_reg;
    assign wc_busy_o   = busy_reg;
endmodule
`default_nettype wire

/* uwo_order_sva.sv */
// Port checks for the ordering block
`timescale 1ns/1ps
`default_nettype none
module uwo_order_sva
(
    input wire logic              clock_i,
    input wire logic              rst_b_i,
    input wire logic              req_valid_i,
    input wire uwo_pkg::uwo_req_t req_i,
    input wire logic              req_ready_o,
    input wire logic              bus_valid_o,
    input wire uwo_pkg::uwo_req_t bus_req_o,
    input wire logic              bus_accept_i,
    input wire logic              bus_retry_i,
    input wire logic              wc_busy_o
);
    import uwo_pkg::*;
    logic [1:0] k;
    logic       st_on;
    logic       ld_on;
    logic       swap_on;
    logic       uc_take;
    logic       wc_take;
    logic       wc_in;
    logic       hold_on;
    // Kind of the request now on the bus
    assign k       = bus_req_o.kind;
    assign st_on   = bus_valid_o && k == 2'h1;
    assign ld_on   = bus_valid_o && k == 2'h2;
    assign swap_on = bus_valid_o && k == 2'h3;
    // Bus acceptances split by kind
    assign uc_take = bus_accept_i && bus_valid_o && k != 2'h0;
    assign wc_take = bus_accept_i && bus_valid_o && k == 2'h0;
    // A write-combine request taken from the core
    assign wc_in   = req_valid_i && req_ready_o && req_i.kind == 2'h0;
    // A bus request still waiting for acceptance
    assign hold_on = bus_valid_o && !bus_accept_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    st_wait_a: assert property (st_on |-> !wc_busy_o)
        else $error("store ahead of wc");
    ld_wait_a: assert property (ld_on |-> !wc_busy_o)
        else $error("load ahead of wc");
    swap_wait_a: assert property (swap_on |-> !wc_busy_o)
        else $error("swap ahead of wc");
    uc_block_a: assert property (uc_take |=> !req_ready_o)
        else $error("taken during uc op");
    retry_keep_a: assert property (bus_retry_i && wc_busy_o |=> wc_busy_o)
        else $error("retried wc dropped");
    in_order_a: assert property (wc_in |-> ##2 bus_valid_o
        && bus_req_o == $past(req_i, 2)) else $error("bad wc issue");
    req_hold_a: assert property (hold_on |=> bus_valid_o
        && $stable(bus_req_o)) else $error("bus request moved");
    wc_count_a: assert property (wc_take |=> wc_busy_o)
        else $error("wc not counted");
    cover property (bus_retry_i);
    cover property (bus_accept_i && ld_on);
    cover property (bus_accept_i && swap_on);
    cover property (bus_accept_i && st_on);
endmodule
bind uwo_order uwo_order_sva u_sva(.clock_i, .rst_b_i, .req_valid_i, .req_i,
    .req_ready_o, .bus_valid_o, .bus_req_o, .bus_accept_i, .bus_retry_i,
    .wc_busy_o);
`default_nettype wire

/* uwo_bus_model.sv */
// Bus agent model: one transaction at a time, retry on demand
`timescale 1ns/1ps
`default_nettype none
module uwo_bus_model
(
    input  wire logic clock_i,
    input  wire logic bus_valid_i,
    input  wire logic retry_i,
    output var  logic accept_o,
    output var  logic done_o,
    output var  logic retry_o
);
    initial {accept_o, done_o, retry_o} = 3'h0;
    // A retried transfer is reissued by the agent itself, then done
    always
    begin
        @(negedge clock_i);
        if (bus_valid_i)
        begin
            accept_o = 1'b1;
            @(negedge clock_i) accept_o = 1'b0;
            repeat (2) @(negedge clock_i);
            if (retry_i)
            begin
                {done_o, retry_o} = 2'h3;
                @(negedge clock_i) {done_o, retry_o} = 2'h0;
                repeat (2) @(negedge clock_i);
            end
            done_o = 1'b1;
            @(negedge clock_i) done_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb.sv */
// Testbench for the ordering block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uwo_pkg::*;
    logic clock_i = 0, rst_b_i = 0, req_valid_i = 0, retry = 0;
    logic req_ready_o, bus_valid_o, acc, done, fail, wc_busy_o;
    uwo_req_t req_i = '0, bus_req_o;
    logic [7:0] log = 8'h00;
    int err_total = 0, num_checks = 0;
    always #25 clock_i = ~clock_i;
    uwo_order u_uwo_order(.clock_i, .rst_b_i, .req_valid_i, .req_i,
        .req_ready_o, .bus_valid_o, .bus_req_o, .bus_accept_i(acc),
        .bus_done_i(done), .bus_retry_i(fail), .wc_busy_o);
    uwo_bus_model u_uwo_bus_model(.clock_i, .bus_valid_i(bus_valid_o),
        .retry_i(retry), .accept_o(acc), .done_o(done), .retry_o(fail));
    logic [7:0] n_acc = 8'h00, wc_acc = 8'h00, wc_fin = 8'h00;
    logic uc_open = 1'b0;
    // Kinds in bus order; bus model of open writes; retry spent once used
    always @(posedge clock_i)
    begin
        if (bus_valid_o && acc)
        begin
            log   <= {log[5:0], bus_req_o.kind};
            n_acc <= n_acc + 8'h01;
            chk(bus_req_o.data[7:0], n_acc + 8'h01);
            if (bus_req_o.kind == 2'h0)
            begin
                wc_acc <= wc_acc + 8'h01;
                chk({7'h00, uc_open}, 8'h00);
            end
            else
            begin
                uc_open <= 1'b1;
                chk(wc_fin, wc_acc);
            end
        end
        if (done && !fail)
        begin
            if (uc_open) uc_open <= 1'b0;
            else wc_fin <= wc_fin + 8'h01;
            if (!uc_open) chk({7'h00, wc_busy_o}, 8'h01);
        end
        if (fail) chk({7'h00, wc_busy_o}, 8'h01);
        if (fail) retry <= 1'b0;
    end
    task automatic chk(logic [7:0] s, logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %0t order %h want %h", $time, s, e);
        end
    endtask
    task send(logic [1:0] k);
        int n;
        @(negedge clock_i);
        {req_valid_i, req_i.kind} = {1'b1, k};
        req_i.data++;
        for (n = 0; n < 99 && req_ready_o !== 1'b1; n++) @(negedge clock_i);
        if (n == 99) err_total++;
        @(negedge clock_i) req_valid_i = 1'b0;
    endtask
    task idle;
        int n;
        for (n = 0; n < 99; n++)
        begin
            if (req_ready_o === 1'b1 && wc_busy_o === 1'b0) break;
            @(negedge clock_i);
        end
        if (n == 99) err_total++;
    endtask
    task t_retry_store;
        retry = 1'b1;
        send(2'h0);
        send(2'h1);
        send(2'h0);
        idle;
        chk(log & 8'h3f, 8'h04);
    endtask
    task t_load_swap;
        send(2'h0);
        send(2'h2);
        send(2'h0);
        send(2'h3);
        idle;
        chk(log, 8'h23);
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clock_i);
        rst_b_i = 1'b1;
        t_retry_store;
        t_load_swap;
        test_done;
    end
    // Watchdog well beyond both scenarios
    initial
    begin
        #200000;
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
